// ---- urxe_top.sv ----
// Overview of operation
// - Buffer holds two words, third keeps shifting
// - Third word into full buffer sets overrun
// - Overrun keeps buffer, shifter gets overwritten
// - Overrun with receive enable raises interrupt
// - Overrun cleared by status then data read
// - Noise flag rises with receive-available flag
// - Noisy word still stored, no own interrupt
// - Noise cleared by status then data read
// - Low stop bit sets framing error
// - Framing error stored per word, reset clears
// - Parity mismatch stored with word when enabled
// - Interrupt is low pulse on enabled event
// - Five sources; receive, overrun and wake gated by receive enable
// - Two transmit enables, one shared receive enable
// - Receive-line wake raises interrupt, no flag
// - Status flags read-only, not auto-cleared
// - Address detect: interrupt only when top bit high
// - Top bit is ninth or eighth bit
// - No address detect: interrupt on every word
// - Available flag cleared by status then data read
// - Ninth bit kept in control one register
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module urxe_top (
    input wire logic clk,
    input wire logic srst,
    // Serial line and baud tick (16x bit rate)
    input wire logic rx_line,
    input wire logic baud16_tick,
    // Transmitter status from the transmit side
    input wire logic tx_empty,
    input wire logic tx_idle,
    input wire logic tx_empty_rise,
    input wire logic tx_idle_rise,
    // Power-down indication from the core
    input wire logic power_down,
    // Interrupt to the core, active low pulse
    output logic uart_irq_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);

    // Control registers
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    // Receive buffer storage and fill
    urxe_pkg::urxe_entry_t buf_r [urxe_pkg::BUF_DEPTH];
    logic [1:0] cnt_r;
    logic rd_ptr_r;
    logic overrun_r;
    // Status-access arming for clear sequence
    logic armed_r;
    // Line side
    urxe_pkg::urxe_state_t st_r;
    logic [3:0] ovs_r;
    logic [3:0] bit_r;
    logic [8:0] shift_r;
    logic [2:0] smp_r;
    logic noise_r;
    logic frm_err_r;
    logic par_err_r;
    logic rx_prev_r;
    // Word completion pulse and its entry
    logic word_done;
    urxe_pkg::urxe_entry_t word_ent;
    // Bus handshake state
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic ar_take;
    logic wr_go;
    logic data_read;
    logic status_read;
    // Derived status
    urxe_pkg::urxe_entry_t head;
    logic [7:0] status;
    logic nine;
    logic maj;
    logic par_calc;
    logic top_bit;
    logic irq_evt;

    assign nine = ctrl1_r[urxe_pkg::C1_NINE];
    assign head = buf_r[rd_ptr_r];
    // Majority of three samples filters single glitches
    assign maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);

    // Error flags come from the head entry, not the newest word
    always_comb begin
        status = 8'h00;
        status[urxe_pkg::ST_PAR_ERR] = (cnt_r != 2'h0) & head.par_err;
        status[urxe_pkg::ST_FRM_ERR] = (cnt_r != 2'h0) & head.frm_err;
        status[urxe_pkg::ST_NOISE] = (cnt_r != 2'h0) & head.noise;
        status[urxe_pkg::ST_OVRUN] = overrun_r;
        status[urxe_pkg::ST_RIDLE] = (st_r == urxe_pkg::RX_IDLE);
        status[urxe_pkg::ST_AVAIL] = (cnt_r != 2'h0);
        status[urxe_pkg::ST_TIDLE] = tx_idle;
        status[urxe_pkg::ST_TXIF] = tx_empty;
    end

    // Oversample capture: ticks within bit, samples at mid-bit
    always_ff @(posedge clk) begin
        if (srst) begin
            ovs_r <= 4'h0;
            smp_r <= 3'h7;
        end else if (baud16_tick) begin
            ovs_r <= (st_r == urxe_pkg::RX_IDLE) ? 4'h0 : ovs_r + 4'h1;
            if (ovs_r == urxe_pkg::OVS_S0) smp_r[0] <= rx_line;
            if (ovs_r == urxe_pkg::OVS_S1) smp_r[1] <= rx_line;
            if (ovs_r == urxe_pkg::OVS_S2) smp_r[2] <= rx_line;
        end
    end

    // Previous line level for wake edge detection
    always_ff @(posedge clk) begin
        if (srst) rx_prev_r <= 1'b1;
        else rx_prev_r <= rx_line;
    end

    // Parity over data; odd type inverts expectation
    always_comb begin
        par_calc = nine ? ^shift_r : ^shift_r[7:0];
        par_calc = par_calc ^ ctrl1_r[urxe_pkg::C1_PRT];
    end

    // Receiver frame sequencer; keeps running while the buffer is full
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= urxe_pkg::RX_IDLE;
            bit_r <= 4'h0;
            shift_r <= 9'h000;
            noise_r <= 1'b0;
            frm_err_r <= 1'b0;
            par_err_r <= 1'b0;
        end else if (baud16_tick) begin
            case (st_r)
                urxe_pkg::RX_IDLE: begin
                    if (!rx_line) begin
                        st_r <= urxe_pkg::RX_START;
                        noise_r <= 1'b0;
                        frm_err_r <= 1'b0;
                        par_err_r <= 1'b0;
                        bit_r <= 4'h0;
                    end
                end
                default: begin
                    if (ovs_r == urxe_pkg::OVS_LAST) begin
                        // Disagreeing samples mark noise in the frame
                        if (smp_r != 3'h0 && smp_r != 3'h7) noise_r <= 1'b1;
                        case (st_r)
                            urxe_pkg::RX_START: begin
                                if (maj) st_r <= urxe_pkg::RX_IDLE; // False start
                                else st_r <= urxe_pkg::RX_DATA;
                            end
                            urxe_pkg::RX_DATA: begin
                                // LSB first; overwriting on overrun is harmless
                                shift_r <= nine ? {maj, shift_r[8:1]}
                                                : {1'b0, maj, shift_r[7:1]};
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == (nine ? 4'h8 : 4'h7)) begin
                                    st_r <= ctrl1_r[urxe_pkg::C1_PAR_EN] ? urxe_pkg::RX_PAR
                                                                      : urxe_pkg::RX_STOP1;
                                end
                            end
                            urxe_pkg::RX_PAR: begin
                                par_err_r <= (maj != par_calc);
                                st_r <= urxe_pkg::RX_STOP1;
                            end
                            urxe_pkg::RX_STOP1: begin
                                if (!maj) frm_err_r <= 1'b1;
                                st_r <= ctrl2_r[urxe_pkg::C2_STOPS] ? urxe_pkg::RX_STOP2
                                                                   : urxe_pkg::RX_IDLE;
                            end
                            urxe_pkg::RX_STOP2: begin
                                if (!maj) frm_err_r <= 1'b1;
                                st_r <= urxe_pkg::RX_IDLE;
                            end
                            default: st_r <= urxe_pkg::RX_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // Word finishes at the last stop sample; flags ride with it
    always_comb begin
        word_done = baud16_tick && (ovs_r == urxe_pkg::OVS_LAST)
            && ((st_r == urxe_pkg::RX_STOP2)
                || (st_r == urxe_pkg::RX_STOP1 && !ctrl2_r[urxe_pkg::C2_STOPS]));
        word_ent.data = shift_r;
        word_ent.frm_err = frm_err_r | ~maj;
        word_ent.par_err = par_err_r;
        word_ent.noise = noise_r | ((smp_r != 3'h0) && (smp_r != 3'h7));
    end

    // Bus handshakes: one read and one write in flight
    assign s_awready = !aw_held_r && !s_bvalid;
    assign s_wready = !w_held_r && !s_bvalid;
    assign s_arready = !s_rvalid;
    assign ar_take = s_arvalid && s_arready;
    assign wr_go = aw_held_r && w_held_r && !s_bvalid;
    assign status_read = ar_take && (s_araddr == urxe_pkg::ADDR_STATUS);
    assign data_read = ar_take && (s_araddr == urxe_pkg::ADDR_RXDATA);

    // Arm on status access; disarm on any data read
    always_ff @(posedge clk) begin
        if (srst) armed_r <= 1'b0;
        else if (status_read) armed_r <= 1'b1;
        else if (data_read) armed_r <= 1'b0;
    end

    // Two-entry buffer; pop needs status access first
    always_ff @(posedge clk) begin
        logic pop;
        logic push;
        pop = data_read && armed_r && (cnt_r != 2'h0);
        push = word_done && ((cnt_r != 2'h2) || pop);
        if (srst) begin
            cnt_r <= 2'h0;
            rd_ptr_r <= 1'b0;
            overrun_r <= 1'b0;
            for (int i = 0; i < urxe_pkg::BUF_DEPTH; i++) buf_r[i] <= '0;
        end else begin
            if (push) buf_r[rd_ptr_r ^ cnt_r[0] ^ pop] <= word_ent;
            if (pop) rd_ptr_r <= ~rd_ptr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
            // A full-buffer word in the cycle of a clearing pop is stored, so the clear sequence wins
            if (word_done && cnt_r == 2'h2 && !pop) overrun_r <= 1'b1;
            else if (data_read && armed_r) overrun_r <= 1'b0;
        end
    end

    // Control registers; ninth bit captured on each word that arrives while the buffer is not full
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl1_r <= urxe_pkg::CTRL1_RST;
            ctrl2_r <= urxe_pkg::CTRL2_RST;
        end else begin
            if (wr_go && wstrb_r[0] && awaddr_r == urxe_pkg::ADDR_CTRL1)
                ctrl1_r[7:1] <= wdata_r[7:1];
            if (wr_go && wstrb_r[0] && awaddr_r == urxe_pkg::ADDR_CTRL2)
                ctrl2_r <= wdata_r[7:0];
            if (word_done && cnt_r != 2'h2)
                ctrl1_r[urxe_pkg::C1_BIT9] <= shift_r[8] & nine;
        end
    end

    // Write channel capture; status writes ignored as flags are read-only
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_bvalid <= 1'b1;
                // Unmapped answers SLVERR; status/data writes are no-ops
                s_bresp <= (awaddr_r == urxe_pkg::ADDR_STATUS || awaddr_r == urxe_pkg::ADDR_RXDATA
                    || awaddr_r == urxe_pkg::ADDR_CTRL1 || awaddr_r == urxe_pkg::ADDR_CTRL2)
                    ? 2'h0 : 2'h2;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read channel; data read returns head word and flags are head's
    always_ff @(posedge clk) begin
        if (srst) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'h0;
        end else if (ar_take) begin
            s_rvalid <= 1'b1;
            s_rresp <= 2'h0;
            case (s_araddr)
                urxe_pkg::ADDR_STATUS: s_rdata <= {24'h000000, status};
                urxe_pkg::ADDR_RXDATA: s_rdata <= {23'h000000, head.data};
                urxe_pkg::ADDR_CTRL1: s_rdata <= {24'h000000, ctrl1_r};
                urxe_pkg::ADDR_CTRL2: s_rdata <= {24'h000000, ctrl2_r};
                default: begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= 2'h2;
                end
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Interrupt combining; qualifying bit depends on word length
    always_comb begin
        top_bit = nine ? shift_r[8] : shift_r[7];
        irq_evt = 1'b0;
        if (word_done && ctrl2_r[urxe_pkg::C2_RX_EN] && cnt_r != 2'h2) begin
            // Noise alone never adds a request
            if (!ctrl2_r[urxe_pkg::C2_ADDR_DET]) irq_evt = 1'b1;
            else if (top_bit) irq_evt = 1'b1;
        end
        if (word_done && cnt_r == 2'h2 && ctrl2_r[urxe_pkg::C2_RX_EN]) irq_evt = 1'b1;
        if (tx_empty_rise && ctrl2_r[urxe_pkg::C2_TEIE]) irq_evt = 1'b1;
        if (tx_idle_rise && ctrl2_r[urxe_pkg::C2_TIIE]) irq_evt = 1'b1;
        // Wake on falling line edge during power down, no flag kept
        if (power_down && rx_prev_r && !rx_line
            && ctrl2_r[urxe_pkg::C2_WAKE] && ctrl2_r[urxe_pkg::C2_RX_EN]) irq_evt = 1'b1;
    end

    // One-cycle low pulse, registered
    always_ff @(posedge clk) begin
        if (srst) uart_irq_n <= 1'b1;
        else uart_irq_n <= ~irq_evt;
    end

endmodule : urxe_top

// ---- urxe_pkg.sv ----
package urxe_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] ADDR_STATUS = 8'h00; // uart_status_register
    localparam logic [7:0] ADDR_RXDATA = 8'h04; // receive_data_register
    localparam logic [7:0] ADDR_CTRL1 = 8'h08; // uart_control_one
    localparam logic [7:0] ADDR_CTRL2 = 8'h0C; // uart_control_two

    // Status field positions
    localparam int ST_PAR_ERR = 0; // parity_error_flag
    localparam int ST_FRM_ERR = 1; // framing_error_flag
    localparam int ST_NOISE = 2; // noise_flag
    localparam int ST_OVRUN = 3; // overrun_flag
    localparam int ST_RIDLE = 4; // Receiver idle
    localparam int ST_AVAIL = 5; // receive_data_available_flag
    localparam int ST_TIDLE = 6; // Transmit idle input
    localparam int ST_TXIF = 7; // Transmit empty input

    // Control one field positions
    localparam int C1_BIT9 = 0; // received_ninth_bit, read only
    localparam int C1_PRT = 4; // Odd parity when set
    localparam int C1_PAR_EN = 5; // parity_enable
    localparam int C1_NINE = 6; // nine_bit_select

    // Control two field positions
    localparam int C2_TEIE = 0; // Transmit empty enable
    localparam int C2_TIIE = 1; // Transmit idle enable
    localparam int C2_RX_EN = 2; // receive_interrupt_enable
    localparam int C2_WAKE = 3; // Wake-up enable
    localparam int C2_STOPS = 4; // Two stop bits
    localparam int C2_ADDR_DET = 5; // address_detect_enable

    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;

    // Oversampling: 16 ticks per bit, sample at ticks 7,8,9
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_S0 = 4'h7;
    localparam logic [3:0] OVS_S1 = 4'h8;
    localparam logic [3:0] OVS_S2 = 4'h9;
    localparam logic [3:0] OVS_MID = 4'h7;

    // Buffer depth
    localparam int BUF_DEPTH = 2;

    // One buffered word with its flags
    typedef struct packed {
        logic [8:0] data;
        logic frm_err;
        logic par_err;
        logic noise;
    } urxe_entry_t;

    // Receiver line states
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} urxe_state_t;

endpackage : urxe_pkg

// ---- urxe_rx_model.sv ----
`timescale 1ns/1ps
// Remote transmitter on the serial line, also the source of the 16x tick
module urxe_rx_model (
    input wire logic clk,
    output logic rx_line,
    output logic baud16_tick
);
    initial rx_line = 1'b1; // Line idles high between frames
    initial baud16_tick = 1'b0;
    // Tick every other clock keeps a frame near 400 cycles
    always @(posedge clk) baud16_tick <= ~baud16_tick;
    // One bit time; noise flips every third tick so any three samples disagree once
    task automatic put_bit(input logic b, input logic noisy);
        for (int t = 0; t < 16; t++) begin
            @(posedge clk iff baud16_tick);
            rx_line <= (noisy && t % 3 == 0) ? ~b : b;
        end
    endtask : put_bit
    // Whole frame, LSB first; bad drives the last stop bit low
    task automatic send(input logic [8:0] d, input int nb, input logic has_par,
                        input logic pbit, input int stops, input logic bad,
                        input logic noisy);
        put_bit(1'b0, 1'b0);
        for (int i = 0; i < nb; i++) put_bit(d[i], noisy && i == 2);
        if (has_par) put_bit(pbit, 1'b0);
        for (int s = 1; s <= stops; s++) put_bit(!(bad && s == stops), 1'b0);
        put_bit(1'b1, 1'b0); // Idle gap so the receiver settles
    endtask : send
    // Short low glitch: a falling edge without a real start bit
    task automatic glitch;
        @(posedge clk);
        rx_line <= 1'b0;
        @(posedge clk);
        rx_line <= 1'b1;
    endtask : glitch
endmodule : urxe_rx_model

// ---- urxe_top_sva.sv ----
`timescale 1ns/1ps
// Watches the interrupt output and the register bus of urxe_top
module urxe_top_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_line,
    input wire logic tx_empty_rise,
    input wire logic tx_idle_rise,
    input wire logic power_down,
    input wire logic uart_irq_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] aw_q; // Address of the write under way
    logic [7:0] w_q; // Data of the write under way
    logic [7:0] ctrl2_sh; // Shadow of the enables, lags the design by one cycle
    // Shadow follows completed writes only, so a refused write never counts
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl2_sh <= urxe_pkg::CTRL2_RST;
        end else begin
            if (s_awvalid && s_awready) aw_q <= s_awaddr;
            if (s_wvalid && s_wready) w_q <= s_wdata[7:0];
            if ($rose(s_bvalid) && aw_q == urxe_pkg::ADDR_CTRL2) ctrl2_sh <= w_q;
        end
    end
    irq_pulse_a: assert property (!uart_irq_n |=> uart_irq_n)
        else $error("interrupt low longer than one cycle");
    tx_empty_irq_a: assert property (tx_empty_rise && ctrl2_sh[0] |-> ##[1:2] !uart_irq_n)
        else $error("enabled transmit empty gave no interrupt");
    tx_idle_irq_a: assert property (tx_idle_rise && ctrl2_sh[1] |-> ##[1:2] !uart_irq_n)
        else $error("enabled transmit idle gave no interrupt");
    wake_irq_a: assert property (power_down && ctrl2_sh[3] && ctrl2_sh[2] && $fell(rx_line)
        |-> ##[1:4] !uart_irq_n) else $error("wake edge gave no interrupt");
    irq_quiet_a: assert property (ctrl2_sh[2:0] == 3'h0 && $past(ctrl2_sh[2:0]) == 3'h0
        |-> uart_irq_n) else $error("interrupt with all sources masked");
    read_width_a: assert property (s_rvalid |-> s_rdata[31:9] == 23'h0)
        else $error("read data above bit 8 not zero");
    ar_refuse_a: assert property (s_rvalid |-> !s_arready)
        else $error("read address taken while answer pending");
    write_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while response pending");
    cover property (!uart_irq_n);
    cover property (s_rvalid);
    cover property (s_bvalid);
endmodule : urxe_top_sva
bind urxe_top urxe_top_sva urxe_top_sva_i (.clk(clk), .srst(srst), .rx_line(rx_line),
    .tx_empty_rise(tx_empty_rise), .tx_idle_rise(tx_idle_rise), .power_down(power_down),
    .uart_irq_n(uart_irq_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid));

// ---- uart_rx_error_and_interrupt_test.sv ----
`timescale 1ns/1ps
module uart_rx_error_and_interrupt_test;
    logic clk, srst, rx_line, baud16_tick, tx_empty, tx_idle, tx_empty_rise, tx_idle_rise;
    logic power_down, uart_irq_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, last_bresp;
    int bad_count, comparisons, irq_cnt, cycles;
    urxe_top urxe_top_i (.clk(clk), .srst(srst), .rx_line(rx_line), .baud16_tick(baud16_tick),
        .tx_empty(tx_empty), .tx_idle(tx_idle), .tx_empty_rise(tx_empty_rise),
        .tx_idle_rise(tx_idle_rise), .power_down(power_down), .uart_irq_n(uart_irq_n),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    urxe_rx_model urxe_rx_model_i (.clk(clk), .rx_line(rx_line), .baud16_tick(baud16_tick));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Counts interrupt pulses; a stretched pulse counts more than once
    always @(posedge clk) if (!srst && uart_irq_n === 1'b0) irq_cnt++;
    // Hang guard sized well above eleven frames plus bus traffic
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Write offers address and data together, releases each once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        last_bresp = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_read
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk(what, exp, d);
    endtask : rd_chk
    // Status first, then data, which pops the head entry
    task automatic pop(input logic [7:0] st, input logic [8:0] d);
        rd_chk(urxe_pkg::ADDR_STATUS, {24'h0, st}, "status");
        rd_chk(urxe_pkg::ADDR_RXDATA, {23'h0, d}, "rx data");
    endtask : pop
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(urxe_pkg::ADDR_STATUS, 32'h90, "status after reset");
        rd_chk(urxe_pkg::ADDR_CTRL2, 32'h0, "ctrl2 after reset");
        axi_write(urxe_pkg::ADDR_STATUS, 32'hFF);
        chk("status write resp", 32'h0, {30'h0, last_bresp});
        tx_idle <= 1'b1;
        rd_chk(urxe_pkg::ADDR_STATUS, 32'hD0, "status after write");
        tx_idle <= 1'b0;
        axi_write(8'h10, 32'h0);
        chk("unmapped write resp", 32'h2, {30'h0, last_bresp});
        axi_read(8'h10, d, r);
        chk("unmapped resp", 32'h2, {30'h0, r});
    endtask : t_reset
    task automatic t_overrun;
        int n0;
        axi_write(urxe_pkg::ADDR_CTRL2, 32'h04);
        n0 = irq_cnt;
        for (int i = 0; i < 3; i++) urxe_rx_model_i.send(9'(9'h0A1 + i), 8, 0, 0, 1, 0, 0);
        chk("overrun irqs", n0 + 3, irq_cnt);
        pop(8'hB8, 9'h0A1);
        pop(8'hB0, 9'h0A2);
        rd_chk(urxe_pkg::ADDR_STATUS, 32'h90, "status drained");
    endtask : t_overrun
    task automatic t_errors;
        int n0;
        axi_write(urxe_pkg::ADDR_CTRL1, 32'h20);
        axi_write(urxe_pkg::ADDR_CTRL2, 32'h14);
        n0 = irq_cnt;
        urxe_rx_model_i.send(9'h05A, 8, 1, 1, 2, 0, 0);
        urxe_rx_model_i.send(9'h03C, 8, 1, 0, 2, 1, 1);
        chk("noise irqs", n0 + 2, irq_cnt);
        pop(8'hB1, 9'h05A);
        pop(8'hB6, 9'h03C);
        axi_write(urxe_pkg::ADDR_CTRL1, 32'h30);
        axi_write(urxe_pkg::ADDR_CTRL2, 32'h04);
        urxe_rx_model_i.send(9'h05A, 8, 1, 1, 1, 0, 0);
        pop(8'hB0, 9'h05A);
    endtask : t_errors
    task automatic t_addr;
        logic [7:0] c1 [5] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'h00};
        logic [8:0] dv [5] = '{9'h07F, 9'h080, 9'h0FF, 9'h155, 9'h07F};
        int n0;
        for (int i = 0; i < 5; i++) begin
            axi_write(urxe_pkg::ADDR_CTRL1, {24'h0, c1[i]});
            axi_write(urxe_pkg::ADDR_CTRL2, i == 4 ? 32'h04 : 32'h24);
            n0 = irq_cnt;
            urxe_rx_model_i.send(dv[i], c1[i][6] ? 9 : 8, 0, 0, 1, 0, 0);
            chk("addr irq", n0 + (i == 4 || dv[i][c1[i][6] ? 8 : 7]), irq_cnt);
            if (c1[i][6]) rd_chk(urxe_pkg::ADDR_CTRL1, {24'h0, c1[i]} | dv[i][8], "ninth");
            pop(8'hB0, c1[i][6] ? dv[i] : {1'b0, dv[i][7:0]});
        end
    endtask : t_addr
    task automatic t_tx_wake;
        int n0;
        for (int i = 0; i < 4; i++) begin
            axi_write(urxe_pkg::ADDR_CTRL2, i);
            n0 = irq_cnt;
            for (int j = 0; j < 2; j++) begin
                {tx_idle_rise, tx_empty_rise} <= 2'b01 << j;
                @(posedge clk);
                {tx_idle_rise, tx_empty_rise} <= 2'b00;
                repeat (6) @(posedge clk);
            end
            chk("tx irqs", n0 + i[0] + i[1], irq_cnt);
        end
        axi_write(urxe_pkg::ADDR_CTRL2, 32'h0C);
        power_down <= 1'b1;
        n0 = irq_cnt;
        urxe_rx_model_i.glitch();
        repeat (40) @(posedge clk);
        chk("wake irq", n0 + 1, irq_cnt);
        power_down <= 1'b0;
        rd_chk(urxe_pkg::ADDR_STATUS, 32'h90, "status after wake");
    endtask : t_tx_wake
    initial begin
        {srst, tx_empty, tx_idle, tx_empty_rise, tx_idle_rise, power_down} <= 6'h30;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 5'h00;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} <= {16'h0, 32'h0, 4'hF};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_overrun();
        t_errors();
        t_addr();
        t_tx_wake();
        end_of_test();
    end
endmodule : uart_rx_error_and_interrupt_test
